//--- src/bbc_pkg.sv
package bbc_pkg;

  // ----------------------------------------------------------------
  // Target addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR_STRAP_LO = 7'h75;
  localparam logic [6:0] I2C_ADDR_STRAP_HI = 7'h74;
  localparam logic [3:0] BYTE_BITS         = 4'h8;
  localparam logic [3:0] ACK_BIT           = 4'h9;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SETPT_A  = 8'h00;
  localparam logic [7:0] REG_SETPT_B  = 8'h01;
  localparam logic [7:0] REG_FB_SEL   = 8'h04;
  localparam logic [7:0] REG_OUT_CTL  = 8'h06;

  localparam logic [7:0] SETPT_A_RST  = 8'h00;
  localparam logic [7:0] SETPT_B_RST  = 8'h00;
  localparam logic [7:0] FB_SEL_RST   = 8'h00;
  localparam logic [7:0] OUT_CTL_RST  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  localparam logic [7:0] SETPT_B_MASK = 8'h07;
  localparam logic [7:0] FB_SEL_MASK  = 8'h83;
  localparam logic [7:0] OUT_CTL_MASK = 8'hb0;

  localparam int OUT_OE_BIT           = 7;
  localparam int OUT_FORCED_DRAIN_BIT = 5;
  localparam int OUT_DRAIN_BIT        = 4;
  localparam int FB_SRC_BIT           = 7;
  localparam int FB_RATIO_LSB         = 0;
  localparam int SETPT_B_BITS         = 3;

  // ----------------------------------------------------------------
  // Reference and soft start
  // ----------------------------------------------------------------
  localparam int DAC_BITS      = 11;
  localparam int DAC_STEPS     = 2048;
  localparam int SS_TIME_US    = 3600;
  localparam int CLK_MHZ       = 250;
  localparam int SS_CYCLES_DEF = SS_TIME_US * CLK_MHZ;
  localparam logic [DAC_BITS-1:0] REF_ZERO = 11'h000;

  // ----------------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SY_SCL    = 0;
  localparam int SY_SDA    = 1;
  localparam int SY_STRAP  = 2;
  localparam int SY_STBY   = 3;
  localparam int SY_ON     = 4;
  localparam int SY_OFF    = 5;
  localparam int SY_LOCK   = 6;
  localparam int SY_VOUT   = 7;
  localparam int SY_EXTSEL = 8;
  localparam int SY_SYNC   = 9;
  localparam int SY_DITH   = 10;
  localparam int SY_N      = 11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PW_SHUT   = 2'b00,
    PW_STBY   = 2'b01,
    PW_ACTIVE = 2'b11
  } bbc_pwr_t;

  typedef enum logic [2:0] {
    I2_IDLE  = 3'b000,
    I2_ADDR  = 3'b001,
    I2_INDEX = 3'b011,
    I2_WRITE = 3'b010,
    I2_READ  = 3'b110
  } bbc_i2c_t;

  typedef struct packed {
    logic       stb;
    logic [7:0] idx;
    logic [7:0] dat;
  } bbc_wr_t;

endpackage

//--- src/bbc_control.sv
`timescale 1ns/1ns
// Operation
// [RULE_01] Answer at target address 75h with strap low, 74h with strap high.
// [RULE_02] Enable between standby and on levels with input good: standby, sample strap.
// [RULE_03] Enable above on level: I2C access and switching are permitted.
// [RULE_04] Controller may configure registers before setting output enable.
// [RULE_05] Output enable rising ramps reference from zero to setpoint over 3.6ms.
// [RULE_06] Enable below off level: shutdown, all functions off, registers to defaults. USE_EXT_SUPPLY and DITHER_EN still follow their pins.
// [RULE_07] Enable high, output enable clear: no switching, I2C still served.
// [RULE_08] Output enable clear with drain bit set: drain until output below 0.8V.
// [RULE_09] Forced drain bit turns discharge on regardless of output enable.
// [RULE_10] Controller keeps forced drain on no longer than 10ms.
// [RULE_11] External supply pin low selects external 5V, high the internal regulator.
// [RULE_12] Dithering is off whenever an external sync clock is present.
// [RULE_13] Feedback source bit: 0 internal divider, 1 external divider.
// [RULE_14] Two-bit ratio field picks one of four internal feedback ratios.
// [RULE_15] Setpoint is 11 bits spread over registers 00h and 01h.
// [RULE_16] Input supply lockout keeps the device disabled regardless of enable.
// [RULE_17] 00h low eight bits, 01h top three; applied once both are written.
// [RULE_18] I2C byte transfers: address, index, data; reads by repeated start.
module bbc_control
  import bbc_pkg::*;
#(
  parameter int SS_CYCLES = SS_CYCLES_DEF
) (
  input  wire logic                MCLK,            // System clock
  input  wire logic                SYS_RST,         // Synchronous reset, active high
  input  wire logic                I2C_SCL,         // Bus clock pin
  input  wire logic                I2C_SDA_IN,      // Bus data pin level
  output logic                     I2C_SDA_OUT,     // Bus data drive value
  output logic                     I2C_SDA_OE_N,    // Low while pulling data low
  input  wire logic                ADDR_STRAP,      // Address strap pin
  input  wire logic                EN_ABOVE_STBY,   // Enable comparator above standby level
  input  wire logic                EN_ABOVE_ON,     // Enable comparator above on level
  input  wire logic                EN_BELOW_OFF,    // Enable comparator below off level
  input  wire logic                VIN_LOCKOUT,     // Input supply below lockout level
  input  wire logic                VOUT_ABOVE_DRAIN,// Output above drain stop level
  input  wire logic                EXT_SUPPLY_SEL,  // External supply select pin
  input  wire logic                SYNC_CLK_SEEN,   // External sync clock present
  input  wire logic                DITHER_CAP,      // Dither capacitor fitted
  output logic                     SWITCH_EN,       // Power stage switching allowed
  output logic [DAC_BITS-1:0]      REF_DAC,         // Reference setpoint to DAC
  output logic                     DRAIN_EN,        // Output discharge current on
  output logic                     USE_EXT_SUPPLY,  // Run from external 5V
  output logic                     DITHER_EN,       // Frequency dithering on
  output logic                     FB_EXTERNAL,     // External feedback divider
  output logic [1:0]               FB_RATIO,        // Internal feedback ratio
  output logic                     STANDBY          // Device in standby
);

  localparam int SS_TICK_RAW = SS_CYCLES / DAC_STEPS;
  localparam int SS_TICK     = (SS_TICK_RAW > 0) ? SS_TICK_RAW : 1;
  localparam int TICK_W      = $clog2(SS_TICK + 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SY_N-1:0] pins_in;
  logic [SY_N-1:0] sync1_ff;
  logic [SY_N-1:0] sync2_ff;

  assign pins_in = {DITHER_CAP, SYNC_CLK_SEEN, EXT_SUPPLY_SEL, VOUT_ABOVE_DRAIN, VIN_LOCKOUT,
                    EN_BELOW_OFF, EN_ABOVE_ON, EN_ABOVE_STBY, ADDR_STRAP, I2C_SDA_IN, I2C_SCL};

  for (genvar gi = 0; gi < SY_N; gi++) begin : g_sync
    always_ff @(posedge MCLK) begin
      // Bus pins start at their idle high level
      if (SYS_RST) begin
        sync1_ff[gi] <= (gi == SY_SCL) || (gi == SY_SDA);
        sync2_ff[gi] <= (gi == SY_SCL) || (gi == SY_SDA);
      end else begin
        sync1_ff[gi] <= pins_in[gi];
        sync2_ff[gi] <= sync1_ff[gi];
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  bbc_pwr_t   pwr_ff;
  bbc_pwr_t   nxt_pwr;
  logic [6:0] addr_ff;
  logic       active;
  logic       regs_clr;

  always_comb begin
    if (sync2_ff[SY_LOCK] || sync2_ff[SY_OFF]) begin
      nxt_pwr = PW_SHUT;                                       // see [RULE_06] see [RULE_16]
    end else if (sync2_ff[SY_ON]) begin
      nxt_pwr = PW_ACTIVE;                                     // see [RULE_03]
    end else if (sync2_ff[SY_STBY] || pwr_ff != PW_SHUT) begin
      nxt_pwr = PW_STBY;                                       // see [RULE_02]
    end else begin
      nxt_pwr = PW_SHUT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pwr_ff <= PW_SHUT;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // Strap caught on leaving shutdown
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      addr_ff <= I2C_ADDR_STRAP_LO;
    end else if (pwr_ff == PW_SHUT && nxt_pwr != PW_SHUT) begin
      addr_ff <= sync2_ff[SY_STRAP] ? I2C_ADDR_STRAP_HI : I2C_ADDR_STRAP_LO; // see [RULE_01] see [RULE_02]
    end
  end

  assign active   = (pwr_ff == PW_ACTIVE);
  assign regs_clr = SYS_RST || (pwr_ff == PW_SHUT);

  // ----------------------------------------------------------------
  // I2C target
  // ----------------------------------------------------------------
  bbc_i2c_t   i2c_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [7:0] index_ff;
  logic       ack_ff;
  logic       nack_ff;
  logic       scl_d_ff;
  logic       sda_d_ff;
  logic       sda_oe_n_ff;
  logic       scl;
  logic       sda;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_rise;
  logic       scl_fall;
  logic       accept;
  logic       drive_low;
  bbc_wr_t    wr;
  logic [7:0] setpt_a_ff;
  logic [7:0] setpt_b_ff;
  logic [7:0] fb_sel_ff;
  logic [7:0] out_ctl_ff;

  assign scl      = sync2_ff[SY_SCL];
  assign sda      = sync2_ff[SY_SDA];
  assign start_ev = scl && scl_d_ff && sda_d_ff && !sda;
  assign stop_ev  = scl && scl_d_ff && !sda_d_ff && sda;
  assign scl_rise = scl && !scl_d_ff;
  assign scl_fall = !scl && scl_d_ff;
  assign accept   = (i2c_ff != I2_ADDR) || (shift_ff[7:1] == addr_ff); // see [RULE_01]

  function automatic logic [7:0] rd_data(input logic [7:0] idx);
    case (idx)
      REG_SETPT_A: rd_data = setpt_a_ff;
      REG_SETPT_B: rd_data = setpt_b_ff;
      REG_FB_SEL:  rd_data = fb_sel_ff;
      REG_OUT_CTL: rd_data = out_ctl_ff;
      default:     rd_data = RD_UNMAPPED;
    endcase
  endfunction

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST || !active) begin
      i2c_ff   <= I2_IDLE;                                      // see [RULE_03]
      bit_ff   <= 4'h0;
      shift_ff <= 8'h00;
      index_ff <= 8'h00;
      ack_ff   <= 1'b0;
      nack_ff  <= 1'b0;
    end else if (start_ev) begin
      i2c_ff <= I2_ADDR;                                        // see [RULE_18]
      bit_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (stop_ev) begin
      i2c_ff <= I2_IDLE;
      ack_ff <= 1'b0;
    end else if (i2c_ff != I2_IDLE) begin
      if (scl_rise) begin
        bit_ff <= bit_ff + 4'h1;
        if (i2c_ff != I2_READ && bit_ff < BYTE_BITS) begin
          shift_ff <= {shift_ff[6:0], sda};
        end
        if (i2c_ff == I2_READ && bit_ff == BYTE_BITS) begin
          nack_ff <= sda;
        end
      end
      if (scl_fall) begin
        if (bit_ff == BYTE_BITS) begin
          if (i2c_ff != I2_READ) begin
            ack_ff <= accept;
          end
          unique case (i2c_ff)
            I2_ADDR:  if (!accept) i2c_ff <= I2_IDLE;
            I2_INDEX: index_ff <= shift_ff;                     // see [RULE_18]
            I2_WRITE: index_ff <= index_ff + 8'h01;
            I2_READ:  index_ff <= index_ff + 8'h01;
          endcase
        end else if (bit_ff == ACK_BIT) begin
          ack_ff <= 1'b0;
          bit_ff <= 4'h0;
          unique case (i2c_ff)
            I2_ADDR: begin
              if (shift_ff[0]) begin
                i2c_ff   <= I2_READ;                            // see [RULE_18]
                shift_ff <= rd_data(index_ff);
              end else begin
                i2c_ff <= I2_INDEX;
              end
            end
            I2_INDEX: i2c_ff <= I2_WRITE;
            I2_WRITE: i2c_ff <= I2_WRITE;
            I2_READ: begin
              if (nack_ff) begin
                i2c_ff <= I2_IDLE;
              end else begin
                shift_ff <= rd_data(index_ff);
              end
            end
          endcase
        end else if (i2c_ff == I2_READ && bit_ff != 4'h0) begin
          shift_ff <= {shift_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Last read bit held until its clock falls, never into the acknowledge clock
  assign drive_low = active && (ack_ff || (i2c_ff == I2_READ && !shift_ff[7] &&
                     (bit_ff < BYTE_BITS || (bit_ff == BYTE_BITS && scl && scl_d_ff))));
  assign wr.stb    = active && scl_fall && bit_ff == BYTE_BITS && i2c_ff == I2_WRITE;
  assign wr.idx    = index_ff;
  assign wr.dat    = shift_ff;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sda_oe_n_ff <= 1'b1;
    end else begin
      sda_oe_n_ff <= !drive_low;                                // see [RULE_07]
    end
  end

  assign I2C_SDA_OUT  = 1'b0;
  assign I2C_SDA_OE_N = sda_oe_n_ff;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic                wrote_a_ff;
  logic                wrote_b_ff;
  logic                apply;
  logic [DAC_BITS-1:0] setpoint_ff;

  // Writable only in the active state, including before output enable
  always_ff @(posedge MCLK) begin
    if (regs_clr) begin
      setpt_a_ff <= SETPT_A_RST;                                // see [RULE_06]
      setpt_b_ff <= SETPT_B_RST;
      fb_sel_ff  <= FB_SEL_RST;
      out_ctl_ff <= OUT_CTL_RST;
    end else if (wr.stb) begin
      case (wr.idx)                                             // see [RULE_04]
        REG_SETPT_A: setpt_a_ff <= wr.dat;
        REG_SETPT_B: setpt_b_ff <= wr.dat & SETPT_B_MASK;
        REG_FB_SEL:  fb_sel_ff  <= wr.dat & FB_SEL_MASK;
        REG_OUT_CTL: out_ctl_ff <= wr.dat & OUT_CTL_MASK;
        default: ;
      endcase
    end
  end

  assign apply = wrote_a_ff && wrote_b_ff;

  // Fresh write wins over the clearing apply
  always_ff @(posedge MCLK) begin
    if (regs_clr) begin
      wrote_a_ff  <= 1'b0;
      wrote_b_ff  <= 1'b0;
      setpoint_ff <= REF_ZERO;
    end else begin
      wrote_a_ff <= (wrote_a_ff && !apply) || (wr.stb && wr.idx == REG_SETPT_A); // see [RULE_17]
      wrote_b_ff <= (wrote_b_ff && !apply) || (wr.stb && wr.idx == REG_SETPT_B);
      if (apply) begin
        setpoint_ff <= {setpt_b_ff[SETPT_B_BITS-1:0], setpt_a_ff}; // see [RULE_15] see [RULE_17]
      end
    end
  end

  // ----------------------------------------------------------------
  // Soft start
  // ----------------------------------------------------------------
  logic                oe;
  logic [DAC_BITS-1:0] ramp_ff;
  logic [TICK_W-1:0]   tick_ff;
  logic                ss_done_ff;
  logic [DAC_BITS-1:0] ref_now;

  assign oe = out_ctl_ff[OUT_OE_BIT];

  always_ff @(posedge MCLK) begin
    if (regs_clr || !oe || !active) begin
      ramp_ff    <= REF_ZERO;                                   // see [RULE_05]
      tick_ff    <= '0;
      ss_done_ff <= 1'b0;
    end else if (!ss_done_ff) begin
      if (ramp_ff >= setpoint_ff) begin
        ss_done_ff <= 1'b1;
      end else if (tick_ff == TICK_W'(SS_TICK - 1)) begin
        tick_ff <= '0;
        ramp_ff <= ramp_ff + 11'h001;                           // see [RULE_05]
      end else begin
        tick_ff <= tick_ff + 1'b1;
      end
    end
  end

  assign ref_now = ss_done_ff ? setpoint_ff : ramp_ff;

  // ----------------------------------------------------------------
  // Converter controls
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      SWITCH_EN      <= 1'b0;
      REF_DAC        <= REF_ZERO;
      DRAIN_EN       <= 1'b0;
      USE_EXT_SUPPLY <= 1'b0;
      DITHER_EN      <= 1'b0;
      FB_EXTERNAL    <= 1'b0;
      FB_RATIO       <= 2'b00;
      STANDBY        <= 1'b0;
    end else begin
      SWITCH_EN      <= active && oe;                           // see [RULE_07] see [RULE_16]
      REF_DAC        <= (active && oe) ? ref_now : REF_ZERO;
      DRAIN_EN       <= active && ((!oe && out_ctl_ff[OUT_DRAIN_BIT] && sync2_ff[SY_VOUT]) || // see [RULE_08]
                                   out_ctl_ff[OUT_FORCED_DRAIN_BIT]);                      // see [RULE_09]
      USE_EXT_SUPPLY <= !sync2_ff[SY_EXTSEL];                   // see [RULE_11]
      DITHER_EN      <= sync2_ff[SY_DITH] && !sync2_ff[SY_SYNC]; // see [RULE_12]
      FB_EXTERNAL    <= fb_sel_ff[FB_SRC_BIT];                  // see [RULE_13]
      FB_RATIO       <= fb_sel_ff[FB_RATIO_LSB +: 2];           // see [RULE_14]
      STANDBY        <= (pwr_ff == PW_STBY);                    // see [RULE_02]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  chk_addr_strap: assert property ((pwr_ff == PW_SHUT && nxt_pwr != PW_SHUT) |=> // see [RULE_01]
      addr_ff == ($past(sync2_ff[SY_STRAP]) ? I2C_ADDR_STRAP_HI : I2C_ADDR_STRAP_LO))
    else $error("address not taken from strap");
  chk_standby_entry: assert property ((!sync2_ff[SY_LOCK] && !sync2_ff[SY_OFF] && sync2_ff[SY_STBY] && // see [RULE_02]
      !sync2_ff[SY_ON]) |=> ##1 STANDBY)
    else $error("standby not entered");
  chk_i2c_gated: assert property ((pwr_ff != PW_ACTIVE) |=> (i2c_ff == I2_IDLE && sda_oe_n_ff)) // see [RULE_03]
    else $error("bus served outside active state");
  chk_ss_start: assert property ((active && $rose(oe)) |=> (REF_DAC == REF_ZERO) ##1 (REF_DAC <= setpoint_ff)) // see [RULE_05]
    else $error("soft start does not begin at zero");
  chk_shut_reset: assert property ((pwr_ff == PW_SHUT) |=> (out_ctl_ff == OUT_CTL_RST && // see [RULE_06]
      setpoint_ff == REF_ZERO && fb_sel_ff == FB_SEL_RST) ##1 !SWITCH_EN)
    else $error("shutdown left state behind");
  chk_switch_off: assert property ((!oe || !active) |=> !SWITCH_EN) // see [RULE_07]
    else $error("switching without output enable");
  chk_drain_stop: assert property ((active && !oe && !out_ctl_ff[OUT_FORCED_DRAIN_BIT] && // see [RULE_08]
      !sync2_ff[SY_VOUT]) |=> !DRAIN_EN)
    else $error("drain kept on below stop level");
  chk_forced_drain: assert property ((active && out_ctl_ff[OUT_FORCED_DRAIN_BIT]) |=> DRAIN_EN) // see [RULE_09]
    else $error("forced drain not applied");
  chk_dither_sync: assert property (sync2_ff[SY_SYNC] |=> !DITHER_EN) // see [RULE_12]
    else $error("dither active with sync clock");
  chk_lockout_off: assert property (sync2_ff[SY_LOCK] |=> ##1 (!SWITCH_EN && !DRAIN_EN)) // see [RULE_16]
    else $error("running during input lockout");
  chk_setpt_apply: assert property ((apply && !regs_clr) |=> // see [RULE_17]
      (setpoint_ff == {$past(setpt_b_ff[2:0]), $past(setpt_a_ff)}))
    else $error("setpoint not applied from both halves");
  chk_ack_match: assert property ((i2c_ff == I2_ADDR && scl_fall && bit_ff == BYTE_BITS && // see [RULE_18]
      shift_ff[7:1] != addr_ff && !start_ev) |=> !ack_ff ##1 sda_oe_n_ff)
    else $error("foreign address acknowledged");

  cov_write_byte: cover property (wr.stb && wr.idx == REG_OUT_CTL);
  cov_read_byte:  cover property (i2c_ff == I2_ADDR ##[1:400] i2c_ff == I2_READ);
  cov_ss_done:    cover property (active && oe ##[1:1000] ss_done_ff);
  cov_shutdown:   cover property (active ##1 pwr_ff == PW_SHUT);

endmodule

//--- verif/bbc_i2c_ctl.sv
`timescale 1ns/1ns
module bbc_i2c_ctl (
  input  wire logic clk,     // System clock
  input  wire logic sda,     // Resolved data wire
  output logic      scl,     // Bus clock drive
  output logic      sda_rel  // High releases data
);
  logic scl_ff = 1'h1;
  logic sda_ff = 1'h1;
  assign scl     = scl_ff;
  assign sda_rel = sda_ff;

  // ----------------------------------------------------------------
  // Bit and frame primitives
  // ----------------------------------------------------------------
  task automatic half();
    repeat (10) @(posedge clk);
  endtask

  task automatic bit_io(input logic b, output logic r);
    half();
    sda_ff <= b;
    half();
    scl_ff <= 1'h1;
    half();
    r = sda;
    scl_ff <= 1'h0;
  endtask

  task automatic start();
    half();
    sda_ff <= 1'h1;
    half();
    scl_ff <= 1'h1;
    half();
    sda_ff <= 1'h0;
    half();
    scl_ff <= 1'h0;
  endtask

  task automatic stop();
    half();
    sda_ff <= 1'h0;
    half();
    scl_ff <= 1'h1;
    half();
    sda_ff <= 1'h1;
    half();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ok = (r === 1'h0);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // ----------------------------------------------------------------
  // Register transfers
  // ----------------------------------------------------------------
  task automatic xfer_wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] dat, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({a, 1'h0}, k0);
    wbyte(idx, k1);
    wbyte(dat, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic xfer_rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({a, 1'h0}, k0);
    wbyte(idx, k1);
    start();
    wbyte({a, 1'h1}, k2);
    rbyte(1'h1, d);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

//--- verif/tb_buck_boost_control_logic.sv
`timescale 1ns/1ns
module tb_buck_boost_control_logic import bbc_pkg::*;;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} bbc_row_t;
  localparam bbc_row_t ROWS [8] = '{'{8'h00, 8'ha5, 8'ha5}, '{8'h01, 8'hff, 8'h07}, '{8'h02, 8'h5a, 8'h00},
    '{8'h04, 8'h80, 8'h80}, '{8'h04, 8'h81, 8'h81}, '{8'h04, 8'h82, 8'h82}, '{8'h04, 8'h03, 8'h03},
    '{8'h04, 8'hff, 8'h83}};
  logic MCLK, SYS_RST, ADDR_STRAP, EN_ABOVE_STBY, EN_ABOVE_ON, EN_BELOW_OFF, VIN_LOCKOUT;
  logic VOUT_ABOVE_DRAIN, EXT_SUPPLY_SEL, SYNC_CLK_SEEN, DITHER_CAP;
  logic I2C_SDA_OUT, I2C_SDA_OE_N, SWITCH_EN, DRAIN_EN, USE_EXT_SUPPLY, DITHER_EN, FB_EXTERNAL, STANDBY;
  logic [DAC_BITS-1:0] REF_DAC;
  logic [1:0]          FB_RATIO;
  wire                 scl, sda_rel, sda_wire;
  logic                ok;
  logic [7:0]          rdat;
  int                  failures = 0;
  int                  num_checks = 0;
  // Open-drain data wire with pull-up
  assign sda_wire = sda_rel & I2C_SDA_OE_N;

  bbc_control #(.SS_CYCLES(4096)) i_bbc_control (.MCLK(MCLK), .SYS_RST(SYS_RST), .I2C_SCL(scl),
    .I2C_SDA_IN(sda_wire), .I2C_SDA_OUT(I2C_SDA_OUT), .I2C_SDA_OE_N(I2C_SDA_OE_N), .ADDR_STRAP(ADDR_STRAP),
    .EN_ABOVE_STBY(EN_ABOVE_STBY), .EN_ABOVE_ON(EN_ABOVE_ON), .EN_BELOW_OFF(EN_BELOW_OFF),
    .VIN_LOCKOUT(VIN_LOCKOUT), .VOUT_ABOVE_DRAIN(VOUT_ABOVE_DRAIN), .EXT_SUPPLY_SEL(EXT_SUPPLY_SEL),
    .SYNC_CLK_SEEN(SYNC_CLK_SEEN), .DITHER_CAP(DITHER_CAP), .SWITCH_EN(SWITCH_EN), .REF_DAC(REF_DAC),
    .DRAIN_EN(DRAIN_EN), .USE_EXT_SUPPLY(USE_EXT_SUPPLY), .DITHER_EN(DITHER_EN), .FB_EXTERNAL(FB_EXTERNAL),
    .FB_RATIO(FB_RATIO), .STANDBY(STANDBY));
  bbc_i2c_ctl i_bbc_i2c_ctl (.clk(MCLK), .sda(sda_wire), .scl(scl), .sda_rel(sda_rel));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    @(negedge MCLK);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    MCLK = 1'h0;
    forever #2 MCLK = ~MCLK;
  end

  initial begin
    #400000;
    failures++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {SYS_RST, ADDR_STRAP, EN_BELOW_OFF, VOUT_ABOVE_DRAIN, EXT_SUPPLY_SEL, DITHER_CAP} = 6'h3f;
    {EN_ABOVE_STBY, EN_ABOVE_ON, VIN_LOCKOUT, SYNC_CLK_SEEN} = 4'h0;
    cyc(6);
    SYS_RST <= 1'h0;
    check(16'({SWITCH_EN, STANDBY, DRAIN_EN, I2C_SDA_OE_N, I2C_SDA_OUT, REF_DAC}), 16'h1000);
    @(posedge MCLK) {EN_BELOW_OFF, EN_ABOVE_STBY} <= 2'h1;
    cyc(8);
    check(16'(STANDBY), 16'h1);
    i_bbc_i2c_ctl.xfer_wr(7'h74, REG_FB_SEL, 8'h83, ok);
    check(16'(ok), 16'h0);
    @(posedge MCLK) EN_ABOVE_ON <= 1'h1;
    cyc(8);
    check(16'(STANDBY), 16'h0);
    i_bbc_i2c_ctl.xfer_wr(7'h75, REG_FB_SEL, 8'h83, ok);
    check(16'(ok), 16'h0);
    foreach (ROWS[i]) begin
      i_bbc_i2c_ctl.xfer_wr(7'h74, ROWS[i].idx, ROWS[i].wd, ok);
      i_bbc_i2c_ctl.xfer_rd(7'h74, ROWS[i].idx, rdat, ok);
      check(16'({ok, rdat}), 16'({1'h1, ROWS[i].rd}));
      if (ROWS[i].idx == REG_FB_SEL)
        check(16'({FB_EXTERNAL, FB_RATIO}), 16'({ROWS[i].rd[7], ROWS[i].rd[1:0]}));
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge MCLK) {DITHER_CAP, SYNC_CLK_SEEN, EXT_SUPPLY_SEL} <= 3'(i);
      cyc(8);
      check(16'({USE_EXT_SUPPLY, DITHER_EN}), 16'({~i[0], i[2] & ~i[1]}));
    end
    // Reset in mid-run clears registers and outputs
    @(posedge MCLK) SYS_RST <= 1'h1;
    cyc(2);
    SYS_RST <= 1'h0;
    check(16'({STANDBY, FB_EXTERNAL, FB_RATIO, I2C_SDA_OE_N, USE_EXT_SUPPLY}), 16'h2);
    i_bbc_i2c_ctl.xfer_rd(7'h74, REG_FB_SEL, rdat, ok);
    check(16'({ok, rdat}), 16'h0100);
    i_bbc_i2c_ctl.xfer_wr(7'h74, REG_FB_SEL, 8'h83, ok);
    i_bbc_i2c_ctl.xfer_wr(7'h74, REG_OUT_CTL, 8'h10, ok);
    check(16'(DRAIN_EN), 16'h1);
    @(posedge MCLK) VOUT_ABOVE_DRAIN <= 1'h0;
    cyc(8);
    check(16'(DRAIN_EN), 16'h0);
    i_bbc_i2c_ctl.xfer_wr(7'h74, REG_OUT_CTL, 8'h20, ok);
    check(16'({DRAIN_EN, SWITCH_EN}), 16'h2);
    i_bbc_i2c_ctl.xfer_wr(7'h74, REG_OUT_CTL, 8'h00, ok);
    @(posedge MCLK) {VIN_LOCKOUT, ADDR_STRAP} <= 2'h2;
    cyc(8);
    check(16'({STANDBY, FB_EXTERNAL, FB_RATIO}), 16'h0);
    @(posedge MCLK) VIN_LOCKOUT <= 1'h0;
    cyc(8);
    i_bbc_i2c_ctl.xfer_rd(7'h75, REG_FB_SEL, rdat, ok);
    check(16'({ok, rdat}), 16'h0100);
    i_bbc_i2c_ctl.xfer_wr(7'h75, REG_SETPT_A, 8'h40, ok);
    i_bbc_i2c_ctl.xfer_wr(7'h75, REG_OUT_CTL, 8'h80, ok);
    cyc(20);
    check(16'({SWITCH_EN, REF_DAC}), 16'h0800);
    i_bbc_i2c_ctl.xfer_wr(7'h75, REG_SETPT_B, 8'h01, ok);
    cyc(4);
    check(16'(REF_DAC), 16'h0140);
    i_bbc_i2c_ctl.xfer_wr(7'h75, REG_OUT_CTL, 8'h00, ok);
    check(16'({SWITCH_EN, REF_DAC}), 16'h0);
    i_bbc_i2c_ctl.xfer_wr(7'h75, REG_OUT_CTL, 8'ha0, ok);
    check(16'({DRAIN_EN, SWITCH_EN, REF_DAC < 11'h140}), 16'h7);
    cyc(700);
    check(16'(REF_DAC), 16'h0140);
    @(posedge MCLK) {EN_BELOW_OFF, EN_ABOVE_ON, EN_ABOVE_STBY} <= 3'h4;
    cyc(8);
    check(16'({SWITCH_EN, DRAIN_EN, STANDBY, REF_DAC}), 16'h0);
    conclude();
  end
endmodule
